// >>> logic/amd_diag_seq.sv
// Top of the amplifier output fault diagnostic sequencer with its bus slave.
// Contract
// [R01] Standby exit with diagnostics runs turn-on test.
// [R02] Turn-on result held; new pulse after read.
// [R03] Pulse first, outputs hi-Z; permanent once biased.
// [R04] Turn-on result kept until new short.
// [R05] Latch status at pulse end, 100 ms.
// [R06] Load thresholds follow line-driver mode only; the code also requires the 12 dB gain bit set.
// [R07] Permanent test ignores open load.
// [R08] Restart mode: faulty channel off, 1 ms checks.
// [R09] Trip rechecked after 1 ms; clear returns active.
// [R10] Overload at check starts 100 ms cycle.
// [R11] Cycle end stores result, channel restarts.
// [R12] Next permanent cycle only after host read.
// [R13] Host polls bytes, above half a second.
// [R14] Flag output offset beyond 2 V.
// [R15] Offset window from previous read to this.
// [R16] Offset must persist; trip suppresses it.
// [R17] Multiple faults reported over successive reads.
// [R18] Double faults resolved by fixed priority.
// [R19] Only faults stable whole period are reported.
// [R20] Every read re-arms; shows previous results.
// [R21] Host turn-on and turn-off timing with mute.
// [R22] Host installation and offset test sequences.
// [R23] First instruction bit 6 enables diagnostics.
// [R24] Done bit set when a cycle has terminated.
// [R25] Channel bit 4 marks permanent result.
// [R26] Second instruction bit 3 selects line thresholds.
// [R27] Read bytes captured together at read start.
//
// Our own choices: the placing of the registers and the Avalon-MM interface to the registers.
`default_nettype none
module amd_diag_seq
  import amd_pkg::*;
#(
  parameter int MS_CYC = MS_CYC_DEF
) (
  input  wire logic        clock,
  input  wire logic        arst_n,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        sense_clk,
  input  wire logic [5:0]  flt_ch1,
  input  wire logic [5:0]  flt_ch2,
  input  wire logic [1:0]  trip_in,
  input  wire logic        amp_biased,
  input  wire logic        therm_warn,
  output logic             outputs_hiz,
  output logic             test_pulse,
  output logic      [1:0]  ch_shutdown,
  output logic             line_drv_thr,
  output logic             gain_12db,
  output logic             amp_enable
);
  localparam int NS = 2 * NF + 5;

  logic          rst_s1_ff;
  logic          rst_n;
  logic [NS-1:0] in_s1_ff;
  logic [NS-1:0] in_s2_ff;
  logic          sck_d_ff;
  logic [2*NF-1:0] flt_smp_ff;
  logic [16:0]   ms_cnt_ff;
  logic          tick_ff;
  logic          wait_ff;
  logic [31:0]   rdata_ff;
  logic [7:0]    instr1_ff;
  logic [7:0]    instr2_ff;
  amd_seq_e      seq_ff;
  logic [6:0]    pul_cnt_ff;
  logic          ton_armed_ff;
  logic          ton_cap_ff;
  logic          meas_clr_ff;
  logic          done_ff;
  logic          ofs_open_ff;
  logic          hiz_ff;
  logic          pulse_ff;
  logic [1:0]    shut_ff;
  logic          line_ff;
  logic          gain_ff;
  logic          amp_en_ff;
  logic          rd_ack;
  logic          wr_ack;
  logic          diag_rd;
  logic          sck_rise;
  logic          biased_s;
  logic          therm_s;
  logic [1:0]    trip_s;
  logic [7:0]    nxt_db1;
  logic [7:0]    nxt_db2;

  amd_chan_if cif [2] ();

  // Reset is released through two flip-flops.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rst_s1_ff <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1_ff <= 1'b1;
      rst_n <= rst_s1_ff;
    end
  end

  // Pins from the analog side pass two flip-flops first.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      in_s1_ff <= '0;
      in_s2_ff <= '0;
    end else begin
      in_s1_ff <= {sense_clk, therm_warn, amp_biased, trip_in, flt_ch2, flt_ch1};
      in_s2_ff <= in_s1_ff;
    end
  end

  assign trip_s = in_s2_ff[2*NF+1:2*NF];
  assign biased_s = in_s2_ff[2*NF+2];
  assign therm_s = in_s2_ff[2*NF+3];
  assign sck_rise = in_s2_ff[NS-1] & ~sck_d_ff;

  // Fault detectors are sampled on each rising edge of the sense clock.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sck_d_ff <= 1'b0;
      flt_smp_ff <= '0;
    end else begin
      sck_d_ff <= in_s2_ff[NS-1];
      if (sck_rise) begin
        flt_smp_ff <= in_s2_ff[2*NF-1:0];
      end
    end
  end

  // Millisecond timebase.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ms_cnt_ff <= '0;
      tick_ff <= 1'b0;
    end else begin
      tick_ff <= (ms_cnt_ff == 17'(MS_CYC - 1));
      if (ms_cnt_ff == 17'(MS_CYC - 1)) begin
        ms_cnt_ff <= '0;
      end else begin
        ms_cnt_ff <= ms_cnt_ff + 17'h00001;
      end
    end
  end

  // Bus handshake: a request is answered one cycle after it is seen.
  assign rd_ack = avs_read & ~wait_ff;
  assign wr_ack = avs_write & ~wait_ff;
  assign diag_rd = rd_ack && avs_address == ADR_DIAG;

  // Diagnostic bytes as they stand now.
  always_comb begin
    nxt_db1 = {therm_s, done_ff, 1'b0, cif[0].res}; // R24 R25
    nxt_db2 = {instr1_ff[B_OFS_EN], 2'b00, cif[1].res};
    nxt_db1[B_OPEN] = cif[0].res[B_OPEN] | cif[0].ofs_flag; // R14
    nxt_db2[B_OPEN] = cif[1].res[B_OPEN] | cif[1].ofs_flag;
  end

  // Wait-state and read data; both bytes are caught at the read start.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wait_ff <= 1'b1;
      rdata_ff <= '0;
    end else begin
      wait_ff <= ~((avs_read | avs_write) & wait_ff);
      if (avs_read && wait_ff) begin
        case (avs_address)
          ADR_INSTR1: rdata_ff <= {24'h000000, instr1_ff};
          ADR_INSTR2: rdata_ff <= {24'h000000, instr2_ff};
          ADR_DIAG:   rdata_ff <= {16'h0000, nxt_db2, nxt_db1}; // R27 R20
          ADR_STAT:   rdata_ff <= {26'h0000000, ton_armed_ff, shut_ff, 1'b0, seq_ff};
          default:    rdata_ff <= '0;
        endcase
      end
    end
  end

  // Instruction registers written by the host.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      instr1_ff <= INSTR1_RST;
      instr2_ff <= INSTR2_RST;
    end else if (wr_ack) begin
      if (avs_address == ADR_INSTR1) begin
        instr1_ff <= avs_writedata[7:0]; // R23
      end
      if (avs_address == ADR_INSTR2) begin
        instr2_ff <= avs_writedata[7:0]; // R26
      end
    end
  end

  // Offset window opens when the enable bit is written from 0 to 1.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ofs_open_ff <= 1'b0;
    end else begin
      ofs_open_ff <= wr_ack && avs_address == ADR_INSTR1
        && avs_writedata[B_OFS_EN] && !instr1_ff[B_OFS_EN]; // R15
    end
  end

  // Turn-on and bias sequence.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      seq_ff <= S_STBY;
      pul_cnt_ff <= '0;
      ton_cap_ff <= 1'b0;
      meas_clr_ff <= 1'b0;
    end else begin
      ton_cap_ff <= 1'b0;
      meas_clr_ff <= 1'b0;
      case (seq_ff)
        S_STBY: begin
          pul_cnt_ff <= '0;
          if (instr2_ff[B_STBY_OFF]) begin
            if (instr1_ff[B_DIAG_EN] && ton_armed_ff) begin
              seq_ff <= S_PULSE; // R01 R02 R03
              meas_clr_ff <= 1'b1;
            end else begin
              seq_ff <= S_BIAS;
            end
          end
        end
        S_PULSE: begin
          if (tick_ff) begin
            pul_cnt_ff <= pul_cnt_ff + 7'h01;
            if (pul_cnt_ff + 7'h01 == ACQ_TK) begin
              ton_cap_ff <= 1'b1; // R05
              seq_ff <= S_BIAS;
            end
          end
        end
        S_BIAS: begin
          if (!instr2_ff[B_STBY_OFF]) begin
            seq_ff <= S_STBY;
          end else if (biased_s) begin
            seq_ff <= S_PLAY; // R03
          end
        end
        S_PLAY: begin
          if (!instr2_ff[B_STBY_OFF]) begin
            seq_ff <= S_STBY;
          end
        end
        default: seq_ff <= S_STBY;
      endcase
    end
  end

  // A new turn-on pulse needs a host read; the read wins.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ton_armed_ff <= 1'b1;
    end else if (diag_rd) begin
      ton_armed_ff <= 1'b1; // R02 R20
    end else if (ton_cap_ff) begin
      ton_armed_ff <= 1'b0;
    end
  end

  // Cycle-terminated flag; a finishing cycle wins over the read clear.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      done_ff <= 1'b0;
    end else if (ton_cap_ff || cif[0].done || cif[1].done) begin
      done_ff <= 1'b1; // R24
    end else if (diag_rd || !instr1_ff[B_DIAG_EN]) begin
      done_ff <= 1'b0;
    end
  end

  // Outputs toward the power stage and threshold selectors.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      hiz_ff <= 1'b1;
      pulse_ff <= 1'b0;
      shut_ff <= '0;
      line_ff <= 1'b0;
      gain_ff <= 1'b0;
      amp_en_ff <= 1'b0;
    end else begin
      hiz_ff <= (seq_ff != S_PLAY); // R03
      pulse_ff <= (seq_ff == S_PULSE);
      shut_ff <= {cif[1].shut, cif[0].shut};
      line_ff <= instr1_ff[B_GAIN12] & instr2_ff[B_LINE_DRV]; // R06 R26
      gain_ff <= instr1_ff[B_GAIN12];
      amp_en_ff <= (seq_ff == S_BIAS) || (seq_ff == S_PLAY);
    end
  end

  assign avs_waitrequest = wait_ff;
  assign avs_readdata = rdata_ff;
  assign outputs_hiz = hiz_ff;
  assign test_pulse = pulse_ff;
  assign ch_shutdown = shut_ff;
  assign line_drv_thr = line_ff;
  assign gain_12db = gain_ff;
  assign amp_enable = amp_en_ff;

  // Two channel units, each fed by its own sampled faults.
  for (genvar i = 0; i < 2; i++) begin : g_ch
    assign cif[i].flt = flt_smp_ff[i*NF +: NF];
    assign cif[i].trip = trip_s[i];
    assign cif[i].tick = tick_ff;
    assign cif[i].diag_on = instr1_ff[B_DIAG_EN] && seq_ff == S_PLAY; // R23 R17
    assign cif[i].rearm = diag_rd; // R20
    assign cif[i].meas_clr = meas_clr_ff;
    assign cif[i].ton_cap = ton_cap_ff;
    assign cif[i].ofs_on = instr1_ff[B_OFS_EN];
    assign cif[i].ofs_open = diag_rd | ofs_open_ff; // R15
    assign cif[i].ofs_close = diag_rd;
    amd_chan u_chan (
      .clock (clock),
      .rst_n (rst_n),
      .cif   (cif[i])
    );
  end

  // Pulse phase: entry with hi-Z outputs, then capture at the end.
  sequence s_pulse_start;
    seq_ff == S_STBY ##1 seq_ff == S_PULSE;
  endsequence
  sequence s_pulse_end;
    seq_ff == S_PULSE && tick_ff && pul_cnt_ff + 7'h01 == ACQ_TK;
  endsequence

  a_pulse_hiz: assert property (@(posedge clock) disable iff (!rst_n) // R03
    s_pulse_start |=> hiz_ff && pulse_ff)
    else $error("test pulse ran without high impedance outputs");
  a_pulse_latch: assert property (@(posedge clock) disable iff (!rst_n) // R05
    s_pulse_end |=> ton_cap_ff && seq_ff == S_BIAS ##1 !ton_cap_ff)
    else $error("turn-on status not latched at pulse end");
  a_pulse_armed: assert property (@(posedge clock) disable iff (!rst_n) // R02
    $rose(seq_ff == S_PULSE) |-> $past(ton_armed_ff))
    else $error("turn-on pulse started without a host read");
  a_bias_first: assert property (@(posedge clock) disable iff (!rst_n) // R03
    $rose(seq_ff == S_PLAY) |-> $past(biased_s) && $past(seq_ff) == S_BIAS)
    else $error("permanent diagnostics began before bias");
  a_read_rearm: assert property (@(posedge clock) disable iff (!rst_n) // R20
    diag_rd |=> ton_armed_ff && wait_ff)
    else $error("host read did not re-arm the turn-on test");
  a_done_flag: assert property (@(posedge clock) disable iff (!rst_n) // R24
    ton_cap_ff |=> done_ff ##1 (done_ff || $past(diag_rd) || !$past(instr1_ff[B_DIAG_EN])))
    else $error("cycle terminated flag not set");
  a_bus_answer: assert property (@(posedge clock) disable iff (!rst_n) // R27
    avs_read && wait_ff && avs_address == ADR_DIAG
      |=> !avs_waitrequest && avs_readdata[15:8] == $past(nxt_db2)
        && avs_readdata[7:0] == $past(nxt_db1))
    else $error("diagnostic bytes not captured at read start");
endmodule
`default_nettype wire

// >>> common/amd_pkg.sv
// Package of constants and types for the amplifier diagnostic sequencer.
`default_nettype none
package amd_pkg;
  // Cycles per millisecond at the 125 MHz clock.
  localparam int CLK_KHZ = 125000;
  localparam int TICK_MS = 1;
  localparam int MS_CYC_DEF = CLK_KHZ * TICK_MS;
  // Timings in milliseconds, counted in millisecond ticks.
  localparam int CHECK_MS = 1;
  localparam int ACQ_MS = 100;
  localparam int DIAG_MS = 100;
  localparam logic [6:0] CHECK_TK = 7'(CHECK_MS / TICK_MS);
  localparam logic [6:0] ACQ_TK = 7'(ACQ_MS / TICK_MS);
  localparam logic [6:0] DIAG_TK = 7'(DIAG_MS / TICK_MS);
  // Register byte addresses.
  localparam logic [3:0] ADR_INSTR1 = 4'h0;
  localparam logic [3:0] ADR_INSTR2 = 4'h4;
  localparam logic [3:0] ADR_DIAG = 4'h8;
  localparam logic [3:0] ADR_STAT = 4'hc;
  localparam logic [7:0] INSTR1_RST = 8'h00;
  localparam logic [7:0] INSTR2_RST = 8'h00;
  // Instruction byte fields.
  localparam int B_DIAG_EN = 6;
  localparam int B_OFS_EN = 5;
  localparam int B_GAIN12 = 4;
  localparam int B_STBY_OFF = 4;
  localparam int B_LINE_DRV = 3;
  // Diagnostic byte fields.
  localparam int B_OPEN = 2;
  localparam int B_PERM = 4;
  localparam int B_DONE = 6;
  localparam int B_THERM = 7;
  localparam int B_OFS_ACT = 7;
  // Fault vector: ground short on positive_output and negative_output,
  // supply_rail short, shorted load, open load, offset.
  localparam int F_GND_POS = 0;
  localparam int F_GND_NEG = 1;
  localparam int F_VCC = 2;
  localparam int F_SHORT = 3;
  localparam int F_OPEN = 4;
  localparam int F_OFS = 5;
  localparam int NF = 6;
  typedef enum logic [1:0] {
    S_STBY = 2'b00, S_PULSE = 2'b01, S_BIAS = 2'b10, S_PLAY = 2'b11
  } amd_seq_e;
  typedef enum logic [1:0] {
    C_ACTIVE = 2'b00, C_CHECK = 2'b01, C_DIAG = 2'b10, C_RESTART = 2'b11
  } amd_ch_e;
endpackage
`default_nettype wire

// >>> common/amd_chan_if.sv
// Interface between the sequencer and one channel diagnostic unit.
`default_nettype none
interface amd_chan_if;
  import amd_pkg::*;
  logic [NF-1:0] flt;
  logic          trip;
  logic          tick;
  logic          diag_on;
  logic          rearm;
  logic          meas_clr;
  logic          ton_cap;
  logic          ofs_on;
  logic          ofs_open;
  logic          ofs_close;
  logic          shut;
  logic          done;
  logic          ofs_flag;
  logic [4:0]    res;
  modport seq (output flt, trip, tick, diag_on, rearm, meas_clr, ton_cap,
               ofs_on, ofs_open, ofs_close, input shut, done, ofs_flag, res);
  modport ch (input flt, trip, tick, diag_on, rearm, meas_clr, ton_cap,
              ofs_on, ofs_open, ofs_close, output shut, done, ofs_flag, res);
endinterface
`default_nettype wire

// >>> logic/amd_chan.sv
// One channel: overload check, permanent diagnostic, restart and offset test.
`default_nettype none
module amd_chan
  import amd_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  amd_chan_if.ch   cif
);
  amd_ch_e    st_ff;
  logic [6:0] cnt_ff;
  logic [NF-1:0] acc_ff;
  logic       armed_ff;
  logic       ofs_acc_ff;
  logic       ofs_trip_ff;
  logic       ofs_run_ff;
  logic       shut_ff;
  logic       done_ff;
  logic       ofs_flag_ff;
  logic [4:0] res_ff;

  // Resolves double faults by priority into {short, open, supply, ground}.
  function automatic logic [3:0] resolve(input logic [NF-1:0] f, input logic perm);
    logic opn;
    opn = f[F_OPEN] & ~perm; // R07
    resolve = 4'h0;
    if (f[F_VCC]) begin
      resolve = {2'b00, 1'b1, f[F_GND_POS]}; // R18
    end else if (f[F_GND_POS] | f[F_GND_NEG]) begin
      if (f[F_GND_NEG] & ~f[F_GND_POS] & opn) begin
        resolve = 4'h4; // R18
      end else begin
        resolve = 4'h1;
      end
    end else if (f[F_SHORT]) begin
      resolve = 4'h8;
    end else if (opn) begin
      resolve = 4'h4;
    end
  endfunction

  // A fault counts only if it held for the whole measurement.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      acc_ff <= '0;
    end else if (cif.meas_clr || (st_ff == C_CHECK && cif.tick && cif.trip)) begin
      acc_ff <= cif.flt;
    end else begin
      acc_ff <= acc_ff & cif.flt; // R19
    end
  end

  // Overload handling state machine.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= C_ACTIVE;
      cnt_ff <= '0;
      done_ff <= 1'b0;
    end else begin
      done_ff <= 1'b0;
      case (st_ff)
        C_ACTIVE: begin
          cnt_ff <= '0;
          if (cif.trip) begin
            // Diagnostic mode only when enabled, playing and re-armed.
            st_ff <= (cif.diag_on && armed_ff) ? C_CHECK : C_RESTART; // R08 R12
          end
        end
        C_CHECK: begin
          if (cif.tick) begin
            cnt_ff <= cnt_ff + 7'h01;
            if (cnt_ff + 7'h01 == CHECK_TK) begin
              cnt_ff <= '0;
              st_ff <= cif.trip ? C_DIAG : C_ACTIVE; // R09 R10
            end
          end
        end
        C_DIAG: begin
          if (cif.tick) begin
            cnt_ff <= cnt_ff + 7'h01;
            if (cnt_ff + 7'h01 == DIAG_TK) begin
              st_ff <= C_RESTART; // R11
              done_ff <= 1'b1;
            end
          end
        end
        C_RESTART: begin
          if (cif.tick && !cif.trip) begin
            st_ff <= C_ACTIVE; // R08
          end
        end
        default: st_ff <= C_ACTIVE;
      endcase
    end
  end

  // Only the channel under overload is switched off.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      shut_ff <= 1'b0;
    end else begin
      shut_ff <= (st_ff != C_ACTIVE); // R08
    end
  end

  // One permanent cycle per host read; the read wins over completion.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      armed_ff <= 1'b1;
    end else if (cif.rearm) begin
      armed_ff <= 1'b1; // R12 R20
    end else if (done_ff) begin
      armed_ff <= 1'b0;
    end
  end

  // Result store: turn-on result stays until a new fault is found.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      res_ff <= '0;
    end else if (cif.ton_cap) begin
      res_ff <= {1'b0, resolve(acc_ff, 1'b0)}; // R01 R05 R25
    end else if (done_ff && resolve(acc_ff, 1'b1) != 4'h0) begin
      res_ff <= {1'b1, resolve(acc_ff, 1'b1)}; // R04 R11 R25
    end
  end

  // Offset window between reads, spoilt by a protection trip.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ofs_acc_ff <= 1'b0;
      ofs_trip_ff <= 1'b0;
      ofs_run_ff <= 1'b0;
      ofs_flag_ff <= 1'b0;
    end else begin
      if (cif.ofs_close) begin
        ofs_flag_ff <= ofs_run_ff & ofs_acc_ff & ~ofs_trip_ff; // R14 R15 R16
      end
      if (cif.ofs_open) begin
        ofs_run_ff <= cif.ofs_on; // R15
        ofs_acc_ff <= 1'b1;
        ofs_trip_ff <= 1'b0;
      end else begin
        ofs_acc_ff <= ofs_acc_ff & cif.flt[F_OFS]; // R16 R19
        ofs_trip_ff <= ofs_trip_ff | cif.trip; // R16
        ofs_run_ff <= ofs_run_ff & cif.ofs_on;
      end
    end
  end

  assign cif.shut = shut_ff;
  assign cif.done = done_ff;
  assign cif.ofs_flag = ofs_flag_ff;
  assign cif.res = res_ff;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  a_check_ends: assert property ( // R09
    st_ff == C_CHECK && cif.tick && cnt_ff + 7'h01 == CHECK_TK && !cif.trip
      |=> st_ff == C_ACTIVE)
    else $error("overload check did not return channel to active");
  a_diag_restart: assert property ( // R11
    st_ff == C_DIAG && cif.tick && cnt_ff + 7'h01 == DIAG_TK
      |=> st_ff == C_RESTART && done_ff ##1 shut_ff && !done_ff)
    else $error("diagnostic end did not store and restart");
  a_restart_shut: assert property ( // R08
    st_ff == C_RESTART |=> shut_ff)
    else $error("restarting channel not shut down");
endmodule
`default_nettype wire

// >>> sim/amd_amp_model.sv
// Behavioural model of the amplifier stage that faces the sequencer.
`default_nettype none
module amd_amp_model (
  input  wire logic clock,
  input  wire logic amp_enable,
  output logic      sense_clk,
  output logic      amp_biased
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [5:0] bias_cnt_ff = 6'h00;
  // The sense clock runs free with an 80 ns period.
  initial begin
    sense_clk = 1'b0;
    forever #40 sense_clk = ~sense_clk;
  end
  // Bias settles some cycles after enable, so play is never entered at once.
  always_ff @(posedge clock) begin
    if (!amp_enable) begin
      bias_cnt_ff <= 6'h00;
    end else if (bias_cnt_ff != 6'h3f) begin
      bias_cnt_ff <= bias_cnt_ff + 6'h01;
    end
  end
  assign amp_biased = amp_enable && (bias_cnt_ff == 6'h3f);
endmodule
`default_nettype wire

// >>> sim/amd_diag_seq_test.sv
// Self-checking testbench of the diagnostic sequencer.
`default_nettype none
module amd_diag_seq_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int MS = 20;
  logic        clock = 1'b0;
  logic        arst_n = 1'b0;
  logic [3:0]  avs_address = 4'h0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        sense_clk;
  logic        amp_biased;
  logic [5:0]  flt_ch1 = 6'h00;
  logic [5:0]  flt_ch2 = 6'h00;
  logic [1:0]  trip_in = 2'b00;
  logic        therm_warn = 1'b0;
  logic        outputs_hiz;
  logic        test_pulse;
  logic [1:0]  ch_shutdown;
  logic        line_drv_thr;
  logic        gain_12db;
  logic        amp_enable;
  logic [31:0] exp_q[$];
  logic [31:0] msk_q[$];
  logic [15:0] rnd = 16'h1650;
  int          failures = 0;
  int          checks_done = 0;
  int          cycles = 0;

  amd_diag_seq #(.MS_CYC(MS)) DUT (.clock(clock), .arst_n(arst_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .sense_clk(sense_clk), .flt_ch1(flt_ch1),
    .flt_ch2(flt_ch2), .trip_in(trip_in), .amp_biased(amp_biased),
    .therm_warn(therm_warn), .outputs_hiz(outputs_hiz), .test_pulse(test_pulse),
    .ch_shutdown(ch_shutdown), .line_drv_thr(line_drv_thr), .gain_12db(gain_12db),
    .amp_enable(amp_enable));
  amd_amp_model amp (.clock(clock), .amp_enable(amp_enable), .sense_clk(sense_clk),
    .amp_biased(amp_biased));

  // The bench clock toggles every half period of 4 ns.
  initial begin
    forever #4 clock = ~clock;
  end

  // Steps the pseudo-random sequence.
  function automatic logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction

  // Prints the verdict and ends the run.
  task automatic report_and_stop();
    if (failures == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Compares one seen value against its expectation.
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    checks_done++;
    if (seen !== want) begin
      failures++;
      $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask

  // One bus transfer, held until the slave drops waitrequest.
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    @(posedge clock);
    while (avs_waitrequest !== 1'b0) @(posedge clock);
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clock);
  endtask

  // A read notes its masked expectation for the monitor.
  task automatic rd(input logic [3:0] a, input logic [31:0] want, input logic [31:0] m);
    exp_q.push_back(want & m);
    msk_q.push_back(m);
    bus(1'b0, a, 32'h0);
  endtask

  task automatic ticks(input int n);
    repeat (n * MS) @(posedge clock);
  endtask

  // The monitor takes the oldest note whenever read data are accepted.
  always @(posedge clock) begin
    if (avs_read && avs_waitrequest === 1'b0 && exp_q.size() > 0) begin
      check(avs_readdata & msk_q.pop_front(), exp_q.pop_front());
    end
  end

  // A hang is cut short after a fixed cycle ceiling.
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      failures++;
      report_and_stop();
    end
  end

  // Main sequence of scenarios.
  initial begin
    int   n;
    logic saw;
    repeat (16) @(posedge clock);
    arst_n <= 1'b1;
    flt_ch1 <= 6'h10;
    repeat (3) @(posedge clock);
    rnd = lfsr(rnd);
    bus(1'b1, 4'h6, {16'h0, rnd});
    rd(4'h2, 32'h0, 32'hffffffff);
    rd(4'h8, 32'h0, 32'h0000ffff);
    bus(1'b1, 4'h0, 32'h40);
    bus(1'b1, 4'h4, 32'h10);
    ticks(1);
    check({30'h0, test_pulse, outputs_hiz}, 32'h3);
    check({31'h0, amp_enable}, 32'h0);
    n = 0;
    while (test_pulse === 1'b1 && n < 3000) begin
      n++;
      @(posedge clock);
    end
    check({31'h0, n >= 97 * MS && n <= 100 * MS}, 32'h1);
    flt_ch1 <= 6'h00;
    therm_warn <= 1'b1;
    ticks(5);
    check({31'h0, outputs_hiz}, 32'h0);
    rd(4'h8, 32'h00c4, 32'h1fdf);
    rd(4'h8, 32'h0084, 32'h1fdf);
    // A trip shorter than the recheck returns the channel to active.
    trip_in <= 2'b01;
    therm_warn <= 1'b0;
    repeat ({1'b0, rnd[2:0]} + 4'h1) @(posedge clock);
    trip_in <= 2'b00;
    saw = 1'b0;
    repeat (3 * MS) begin
      @(posedge clock);
      saw |= ch_shutdown[0];
    end
    check({29'h0, saw, ch_shutdown}, 32'h4);
    // A lasting overload with an open load runs a full permanent cycle.
    flt_ch1 <= 6'h11;
    trip_in <= 2'b01;
    ticks(3);
    check({30'h0, ch_shutdown}, 32'h1);
    ticks(104);
    rd(4'h8, 32'h0051, 32'h1fdf);
    check({30'h0, ch_shutdown}, 32'h1);
    flt_ch1 <= 6'h00;
    trip_in <= 2'b00;
    flt_ch2 <= 6'h20;
    ticks(3);
    check({30'h0, ch_shutdown}, 32'h0);
    // Offset windows, one held throughout and one broken part way.
    bus(1'b1, 4'h0, 32'h60);
    ticks(30);
    rd(4'h8, 32'h0, 32'h0);
    ticks(30);
    rd(4'h8, 32'h8400, 32'h8400);
    ticks(10);
    flt_ch2 <= 6'h00;
    repeat (200) @(posedge clock);
    flt_ch2 <= 6'h20;
    ticks(20);
    rd(4'h8, 32'h0, 32'h0);
    rd(4'h8, 32'h8000, 32'h8400);
    flt_ch2 <= 6'h00;
    // Every gain and threshold combination.
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, 4'h0, {24'h0, 3'h2, i[1], 4'h0});
      bus(1'b1, 4'h4, {24'h0, 4'h1, i[0], 3'h0});
      repeat (4) @(posedge clock);
      check({30'h0, gain_12db, line_drv_thr}, {30'h0, i[1], i[1] & i[0]});
    end
    bus(1'b1, 4'h0, 32'h0);
    rd(4'h8, 32'h0, 32'h0040);
    bus(1'b1, 4'h4, 32'h0);
    ticks(1);
    check({30'h0, outputs_hiz, amp_enable}, 32'h2);
    rd(4'hc, 32'h20, 32'hffffffff);
    report_and_stop();
  end
endmodule
`default_nettype wire
